// [hdl/mode_set_cfg.svh]
`ifndef MODE_SET_CFG_SVH
`define MODE_SET_CFG_SVH

// Instruction match patterns and masks
`define OP_DAC_MODE        16'h3584
`define MASK_DAC_MODE      16'hfffc
`define OP_RAM_MODE        16'h3580
`define MASK_RAM_MODE      16'hfffc
`define OP_EOA_MODE        16'h3520
`define MASK_EOA_MODE      16'hfff8
`define OP_FLAG_SET        16'h34e0
`define MASK_FLAG_SET      16'hffe0
`define OP_FW_MODE         16'h3590
`define MASK_FW_MODE       16'hfffe
`define OP_CTRL_BIT        16'h3740
`define MASK_CTRL_BIT      16'hffe8

// Operand field positions
`define MODE_FIELD_LSB     0
`define EOA_MASK_BIT       2
`define FLAG_LEVEL_BIT     4
`define FLAG_INDEX_LSB     0
`define CTRL_INDEX_LSB     0
`define FW_MODE_BIT        0

// DAC slice access codes
`define DAC_SLICE_BOOST    2'h0
`define DAC_SLICE_VALUE    2'h1
`define DAC_SLICE_OFFSET   2'h2
`define DAC_SLICE_FULL     2'h3

// Data RAM read codes
`define RAM_READ_WORD      2'h0
`define RAM_READ_LOW       2'h1
`define RAM_READ_HIGH      2'h2
`define RAM_READ_SWAP      2'h3

// Bootstrap switch codes
`define BS_KEEP            2'h0
`define BS_ON              2'h1
`define BS_NEUTRAL         2'h2
`define BS_OFF             2'h3

// DAC data field positions on the access bus
`define DAC_VALUE_LSB      0
`define DAC_OFFSET_LSB     8
`define DAC_NEG_LSB        8

// Output codes shared with the output-select operand
`define OUT_HS1            4'h0
`define OUT_HS2            4'h1
`define OUT_HS3            4'h2
`define OUT_HS4            4'h3
`define OUT_HS5            4'h4
`define OUT_LS4            4'h8
`define OUT_LS5            4'h9
`define OUT_LS6            4'ha
`define OUT_LS7            4'hb
`define OUT_NONE           4'hc

// Reset values
`define RST_DAC_SLICE      `DAC_SLICE_VALUE
`define RST_RAM_READ       `RAM_READ_WORD
`define RST_BS_MODE        `BS_OFF
`define RST_HS_MASK        1'b0
`define RST_FW_AUTO        1'b0

`endif

// [hdl/mode_set_pkg.sv]
package mode_set_pkg;
    typedef logic [1:0] slice_code_t;
    typedef logic [1:0] ram_code_t;
    typedef logic [1:0] bs_code_t;
    typedef logic [3:0] out_code_t;
endpackage

// [hdl/mode_bus_if.sv]
`timescale 1ns/1ps
interface mode_bus_if;
    import mode_set_pkg::*;
    slice_code_t dacSliceSelect;
    ram_code_t   ramReadSelect;
    modport source  (output dacSliceSelect, output ramReadSelect);
    modport dacSide (input dacSliceSelect);
    modport ramSide (input ramReadSelect);
endinterface

// [hdl/dac_slice_router.sv]
`timescale 1ns/1ps
`include "mode_set_cfg.svh"
module dac_slice_router import mode_set_pkg::*; (
    mode_bus_if.dacSide     modeBus,
    input  wire logic       accessShared,
    input  wire logic [7:0] dacValue,
    input  wire logic [5:0] dacOffset,
    input  wire logic [7:0] dac4hValue,
    input  wire logic [3:0] dacNegValue,
    input  wire logic [7:0] dacBoostValue,
    output logic      [15:0] readWord,
    output logic            selValue,
    output logic            selOffset,
    output logic            sel4h,
    output logic            selNeg,
    output logic            selBoost
);
    // Slice selection from the current access mode and target address
    always_comb begin
        selValue  = 1'b0;
        selOffset = 1'b0;
        sel4h     = 1'b0;
        selNeg    = 1'b0;
        selBoost  = 1'b0;
        unique case (modeBus.dacSliceSelect)
            `DAC_SLICE_BOOST: begin
                selBoost = accessShared;
            end
            `DAC_SLICE_VALUE: begin
                selValue = !accessShared;
                sel4h    = accessShared;
            end
            `DAC_SLICE_OFFSET: begin
                selOffset = !accessShared;
                selNeg    = accessShared;
            end
            `DAC_SLICE_FULL: begin
                selValue  = !accessShared;
                selOffset = !accessShared;
                sel4h     = accessShared;
                selNeg    = accessShared;
            end
        endcase
    end

    // Read word assembly, unselected slices read as zero
    always_comb begin
        readWord = 16'h0000;
        if (selValue)  readWord[`DAC_VALUE_LSB +: 8]  = dacValue;
        if (sel4h)     readWord[`DAC_VALUE_LSB +: 8]  = dac4hValue;
        if (selBoost)  readWord[`DAC_VALUE_LSB +: 8]  = dacBoostValue;
        if (selOffset) readWord[`DAC_OFFSET_LSB +: 6] = dacOffset;
        if (selNeg)    readWord[`DAC_NEG_LSB +: 4]    = dacNegValue;
    end
endmodule

// [hdl/ram_read_formatter.sv]
`timescale 1ns/1ps
`include "mode_set_cfg.svh"
module ram_read_formatter import mode_set_pkg::*; (
    mode_bus_if.ramSide      modeBus,
    input  wire logic [15:0] sourceWord,
    output logic      [15:0] formattedWord
);
    // Byte selection for loads from data memory
    always_comb begin
        unique case (modeBus.ramReadSelect)
            `RAM_READ_WORD: formattedWord = sourceWord;
            `RAM_READ_LOW:  formattedWord = {8'h00, sourceWord[7:0]};
            `RAM_READ_HIGH: formattedWord = {8'h00, sourceWord[15:8]};
            `RAM_READ_SWAP: formattedWord = {sourceWord[7:0], sourceWord[15:8]};
        endcase
    end
endmodule

// [hdl/microcore_mode_set.sv]
`timescale 1ns/1ps
`include "mode_set_cfg.svh"
// Summary of operation
// - Bits 1:0 of the DAC mode instruction pick boost, value, offset or full.
// - Value mode maps DAC address to value, shared address to 4h; low byte.
// - Offset mode reads offset in bits 13-8, negative threshold in 11-8.
// - Full mode covers value plus offset, or 4h plus negative, per access.
// - Shared address reaches boost in boost mode; DAC address reaches nothing.
// - DAC access mode resets to value mode.
// - Data RAM read mode is bits 1:0: word, low, high, swap.
// - Low mode returns the low byte with upper byte zero.
// - High mode returns the high byte in low position, upper byte zero.
// - Swap mode exchanges bytes; word mode passes all sixteen bits.
// - Read mode applies to later loads; resets to word.
// - End-of-actuation switch code applies to every high side this core drives.
// - Mask bit forces the source threshold to zero, else threshold register.
// - Reset leaves thresholds unmasked and bootstrap forced off.
// - Flag instruction writes bit 4 level into flag chosen by bits 3:0.
// - Freewheel instruction bit 0 selects manual or automatic control.
// - Automatic freewheel driver follows the first shortcut high side.
// - Freewheel mode change needs drive rights for the freewheel output.
// - Freewheel control resets to manual.
// - Control bit instruction sets bits 0 to 7 via a three-bit index.
module microcore_mode_set import mode_set_pkg::*; #(
    parameter int NUM_HS    = 5,
    parameter int NUM_FLAGS = 16
) (
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    input  wire logic                  instrValid,
    input  wire logic [15:0]           instrWord,
    input  wire logic [11:0]           outputAccess,
    input  wire logic [3:0]            firstShortcut,
    input  wire logic [NUM_HS*3-1:0]   highSideThresholdReg,
    input  wire logic                  dacAccess,
    input  wire logic                  dacShared,
    input  wire logic                  dacWrite,
    input  wire logic [15:0]           dacWrData,
    input  wire logic                  ramLoad,
    input  wire logic [15:0]           ramWord,
    output logic      [1:0]            dacSliceSelect,
    output logic      [1:0]            ramReadSelect,
    output logic      [15:0]           dacRdData,
    output logic                       dacRdValid,
    output logic      [15:0]           loadData,
    output logic                       loadValid,
    output logic      [NUM_HS*2-1:0]   bootstrapMode,
    output logic      [NUM_HS*3-1:0]   hsThreshold,
    output logic      [NUM_FLAGS-1:0]  flagBits,
    output logic                       freewheelAuto,
    output logic      [3:0]            freewheelDriver,
    output logic      [7:0]            controlBits
);
    // Operand encodings fix these sizes
    if (NUM_HS != 5) begin : g_hs_check
        $error("NUM_HS must be 5");
    end
    if (NUM_FLAGS != 16) begin : g_flag_check
        $error("NUM_FLAGS must be 16");
    end

    typedef struct packed {
        slice_code_t                dacSlice;
        ram_code_t                  ramRead;
        logic [NUM_HS*2-1:0]        bsMode;
        logic [NUM_HS-1:0]          hsMask;
        logic [NUM_HS*3-1:0]        hsThr;
        logic [NUM_FLAGS-1:0]       flags;
        logic                       fwAuto;
        out_code_t                  fwDriver;
        logic [7:0]                 ctrlBits;
        logic [7:0]                 dacValue;
        logic [5:0]                 dacOffset;
        logic [7:0]                 dac4h;
        logic [3:0]                 dacNeg;
        logic [7:0]                 dacBoost;
        logic [15:0]                rdData;
        logic                       rdValid;
        logic [15:0]                ldData;
        logic                       ldValid;
    } core_state_t;

    core_state_t s_q;
    core_state_t s_d;

    mode_bus_if modeBus ();

    logic [15:0] routedRead;
    logic        selValue;
    logic        selOffset;
    logic        sel4h;
    logic        selNeg;
    logic        selBoost;
    logic [15:0] formattedWord;
    logic        isDacMode;
    logic        isRamMode;
    logic        isEoa;
    logic        isFlag;
    logic        isFw;
    logic        isCtrl;
    out_code_t   fwTarget;
    logic        fwRight;
    logic        dacWrEn;

    // Current modes go to the slice router and load formatter
    assign modeBus.dacSliceSelect = s_q.dacSlice;
    assign modeBus.ramReadSelect  = s_q.ramRead;

    dac_slice_router u_router (
        .modeBus       (modeBus),
        .accessShared  (dacShared),
        .dacValue      (s_q.dacValue),
        .dacOffset     (s_q.dacOffset),
        .dac4hValue    (s_q.dac4h),
        .dacNegValue   (s_q.dacNeg),
        .dacBoostValue (s_q.dacBoost),
        .readWord      (routedRead),
        .selValue      (selValue),
        .selOffset     (selOffset),
        .sel4h         (sel4h),
        .selNeg        (selNeg),
        .selBoost      (selBoost)
    );

    ram_read_formatter u_format (
        .modeBus       (modeBus),
        .sourceWord    (ramWord),
        .formattedWord (formattedWord)
    );

    // Instruction decode
    assign isDacMode = instrValid && ((instrWord & `MASK_DAC_MODE) == `OP_DAC_MODE);
    assign isRamMode = instrValid && ((instrWord & `MASK_RAM_MODE) == `OP_RAM_MODE);
    assign isEoa     = instrValid && ((instrWord & `MASK_EOA_MODE) == `OP_EOA_MODE);
    assign isFlag    = instrValid && ((instrWord & `MASK_FLAG_SET) == `OP_FLAG_SET);
    assign isFw      = instrValid && ((instrWord & `MASK_FW_MODE) == `OP_FW_MODE);
    assign isCtrl    = instrValid && ((instrWord & `MASK_CTRL_BIT) == `OP_CTRL_BIT);
    assign dacWrEn   = dacAccess && dacWrite;

    // Freewheel driver paired with the first shortcut high side
    always_comb begin
        unique case (firstShortcut)
            `OUT_HS1: fwTarget = `OUT_LS5;
            `OUT_HS2: fwTarget = `OUT_LS6;
            `OUT_HS3: fwTarget = `OUT_LS7;
            `OUT_HS4: fwTarget = `OUT_HS5;
            `OUT_HS5: fwTarget = `OUT_LS4;
            default:  fwTarget = `OUT_NONE;
        endcase
    end

    // No right exists for an undefined freewheel target
    assign fwRight = (fwTarget != `OUT_NONE) && outputAccess[fwTarget];

    // Next-state computation; updates land at the edge ending the instruction
    always_comb begin
        s_d = s_q;
        s_d.rdValid = 1'b0;
        s_d.ldValid = 1'b0;

        if (isDacMode) begin
            s_d.dacSlice = instrWord[`MODE_FIELD_LSB +: 2];
        end
        if (isRamMode) begin
            s_d.ramRead = instrWord[`MODE_FIELD_LSB +: 2];
        end

        // End of actuation applies only to high sides this core may drive
        if (isEoa) begin
            for (int i = 0; i < NUM_HS; i++) begin
                if (outputAccess[i]) begin
                    if (instrWord[1:0] != `BS_KEEP) begin
                        s_d.bsMode[i*2 +: 2] = instrWord[1:0];
                    end
                    s_d.hsMask[i] = instrWord[`EOA_MASK_BIT];
                end
            end
        end

        // Source thresholds follow the register unless masked
        for (int i = 0; i < NUM_HS; i++) begin
            s_d.hsThr[i*3 +: 3] = s_q.hsMask[i] ? 3'h0
                                                : highSideThresholdReg[i*3 +: 3];
        end

        if (isFlag) begin
            s_d.flags[instrWord[`FLAG_INDEX_LSB +: 4]] = instrWord[`FLAG_LEVEL_BIT];
        end
        if (isCtrl) begin
            s_d.ctrlBits[instrWord[`CTRL_INDEX_LSB +: 3]] = instrWord[`FLAG_LEVEL_BIT];
        end
        if (isFw && fwRight) begin
            s_d.fwAuto = instrWord[`FW_MODE_BIT];
        end

        // Driver handed to the output stage while automatic control is on
        s_d.fwDriver = s_d.fwAuto ? fwTarget : `OUT_NONE;

        // DAC slice writes use the router's selection
        if (dacWrEn) begin
            if (selValue)  s_d.dacValue  = dacWrData[`DAC_VALUE_LSB +: 8];
            if (sel4h)     s_d.dac4h     = dacWrData[`DAC_VALUE_LSB +: 8];
            if (selBoost)  s_d.dacBoost  = dacWrData[`DAC_VALUE_LSB +: 8];
            if (selOffset) s_d.dacOffset = dacWrData[`DAC_OFFSET_LSB +: 6];
            if (selNeg)    s_d.dacNeg    = dacWrData[`DAC_NEG_LSB +: 4];
        end

        // DAC reads answer one cycle after the access
        if (dacAccess && !dacWrite) begin
            s_d.rdData  = routedRead;
            s_d.rdValid = 1'b1;
        end

        // Loads are formatted by the mode already in force
        if (ramLoad) begin
            s_d.ldData  = formattedWord;
            s_d.ldValid = 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q          <= '0;
            s_q.dacSlice <= `RST_DAC_SLICE;
            s_q.ramRead  <= `RST_RAM_READ;
            s_q.bsMode   <= {NUM_HS{`RST_BS_MODE}};
            s_q.hsMask   <= {NUM_HS{`RST_HS_MASK}};
            s_q.fwAuto   <= `RST_FW_AUTO;
            s_q.fwDriver <= `OUT_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign dacSliceSelect  = s_q.dacSlice;
    assign ramReadSelect   = s_q.ramRead;
    assign dacRdData       = s_q.rdData;
    assign dacRdValid      = s_q.rdValid;
    assign loadData        = s_q.ldData;
    assign loadValid       = s_q.ldValid;
    assign bootstrapMode   = s_q.bsMode;
    assign hsThreshold     = s_q.hsThr;
    assign flagBits        = s_q.flags;
    assign freewheelAuto   = s_q.fwAuto;
    assign freewheelDriver = s_q.fwDriver;
    assign controlBits     = s_q.ctrlBits;
endmodule

// [testbench/mode_set_props.sv]
`timescale 1ns/1ps
`include "mode_set_cfg.svh"
module mode_set_props import mode_set_pkg::*; #(
    parameter int NUM_HS    = 5,
    parameter int NUM_FLAGS = 16
) (
    input wire logic                 ref_clk,
    input wire logic                 reset_n,
    input wire logic                 instrValid,
    input wire logic [15:0]          instrWord,
    input wire logic [11:0]          outputAccess,
    input wire logic                 dacAccess,
    input wire logic                 dacWrite,
    input wire logic                 ramLoad,
    input wire logic [15:0]          ramWord,
    input wire logic [1:0]           dacSliceSelect,
    input wire logic [1:0]           ramReadSelect,
    input wire logic                 dacRdValid,
    input wire logic [15:0]          loadData,
    input wire logic                 loadValid,
    input wire logic [NUM_HS*2-1:0]  bootstrapMode,
    input wire logic [NUM_FLAGS-1:0] flagBits,
    input wire logic                 freewheelAuto,
    input wire logic [3:0]           freewheelDriver,
    input wire logic [7:0]           controlBits
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic isDac, isRam, isFlag, isCtrl, isEoa;
    // Opcode matches
    assign isDac  = instrValid && ((instrWord & `MASK_DAC_MODE) == `OP_DAC_MODE);
    assign isRam  = instrValid && ((instrWord & `MASK_RAM_MODE) == `OP_RAM_MODE);
    assign isFlag = instrValid && ((instrWord & `MASK_FLAG_SET) == `OP_FLAG_SET);
    assign isCtrl = instrValid && ((instrWord & `MASK_CTRL_BIT) == `OP_CTRL_BIT);
    assign isEoa  = instrValid && ((instrWord & `MASK_EOA_MODE) == `OP_EOA_MODE);
    property p_slice_set; isDac |=> dacSliceSelect == $past(instrWord[1:0]); endproperty
    a_slice_set: assert property (p_slice_set)
        else $error("slice mode not taken from instruction");
    property p_ram_set; isRam |=> ramReadSelect == $past(instrWord[1:0]); endproperty
    a_ram_set: assert property (p_ram_set)
        else $error("read mode not taken from instruction");
    property p_reset_modes;
        $rose(reset_n) |-> dacSliceSelect == `DAC_SLICE_VALUE
            && ramReadSelect == `RAM_READ_WORD && !freewheelAuto;
    endproperty
    a_reset_modes: assert property (p_reset_modes)
        else $error("modes wrong after reset");
    property p_load_swap;
        ramLoad && ramReadSelect == `RAM_READ_SWAP
            |=> loadValid && loadData == {$past(ramWord[7:0]), $past(ramWord[15:8])};
    endproperty
    a_load_swap: assert property (p_load_swap)
        else $error("swapped load wrong");
    property p_load_low;
        ramLoad && ramReadSelect == `RAM_READ_LOW |=> loadData == {8'h00, $past(ramWord[7:0])};
    endproperty
    a_load_low: assert property (p_load_low)
        else $error("low byte load wrong");
    property p_load_high;
        ramLoad && ramReadSelect == `RAM_READ_HIGH |=> loadData == {8'h00, $past(ramWord[15:8])};
    endproperty
    a_load_high: assert property (p_load_high)
        else $error("high byte load wrong");
    property p_read_answer; dacAccess && !dacWrite |=> dacRdValid; endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read answer missing");
    property p_flag_set;
        isFlag |=> flagBits[$past(instrWord[3:0])] == $past(instrWord[4]);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag not written");
    property p_ctrl_set;
        isCtrl |=> controlBits[$past(instrWord[2:0])] == $past(instrWord[4]);
    endproperty
    a_ctrl_set: assert property (p_ctrl_set)
        else $error("control bit not written");
    property p_eoa_hs1;
        isEoa && instrWord[1:0] != `BS_KEEP && outputAccess[0]
            |=> bootstrapMode[1:0] == $past(instrWord[1:0]);
    endproperty
    a_eoa_hs1: assert property (p_eoa_hs1)
        else $error("switch code not applied");
    property p_fw_idle; !freewheelAuto |-> freewheelDriver == `OUT_NONE; endproperty
    a_fw_idle: assert property (p_fw_idle)
        else $error("manual mode shows a driver");
    c_swap: cover property (ramLoad && ramReadSelect == `RAM_READ_SWAP);
    c_auto: cover property ($rose(freewheelAuto));
    c_read: cover property (dacAccess && !dacWrite && dacSliceSelect == `DAC_SLICE_FULL);
endmodule

// [testbench/microcore_sequencer.sv]
`timescale 1ns/1ps
module microcore_sequencer (
    input  wire logic        ref_clk,
    output logic             instrValid,
    output logic      [15:0] instrWord
);
    // Idle at time zero
    initial begin
        instrValid = 1'b0;
        instrWord  = 16'h0000;
    end
    // One instruction executes for one cycle, launched just after an edge
    task automatic issue(input logic [15:0] w);
        @(posedge ref_clk);
        #1;
        instrValid = 1'b1;
        instrWord  = w;
        @(posedge ref_clk);
        #1;
        instrValid = 1'b0;
        instrWord  = ~w; // Idle word never repeats the last one
    endtask
endmodule

// [testbench/tb_microcore_mode_set.sv]
`timescale 1ns/1ps
module tb_microcore_mode_set import mode_set_pkg::*;;
    logic ref_clk, reset_n, instrValid, dacAccess, dacShared, dacWrite, ramLoad;
    logic [15:0] instrWord, dacWrData, ramWord, dacRdData, loadData, w;
    logic [11:0] outputAccess;
    logic [3:0]  firstShortcut, drv;
    logic [14:0] hsReg, hsThreshold;
    logic [1:0]  dacSliceSelect, ramReadSelect;
    logic        dacRdValid, loadValid, freewheelAuto, l;
    logic [9:0]  bootstrapMode, mBs;
    logic [15:0] flagBits, mFlags;
    logic [3:0]  freewheelDriver;
    logic [7:0]  controlBits, mCtrl, mVal, mH4, mBst;
    logic [5:0]  mOff;
    logic [3:0]  mNeg;
    logic [4:0]  mMask;
    logic [2:0]  c;
    integer      seed, miscompares, samplesChecked, i, m, s, h;
    microcore_sequencer seq (.ref_clk(ref_clk), .instrValid(instrValid), .instrWord(instrWord));
    microcore_mode_set uut (.ref_clk(ref_clk), .reset_n(reset_n), .instrValid(instrValid),
        .instrWord(instrWord), .outputAccess(outputAccess), .firstShortcut(firstShortcut),
        .highSideThresholdReg(hsReg), .dacAccess(dacAccess), .dacShared(dacShared),
        .dacWrite(dacWrite), .dacWrData(dacWrData), .ramLoad(ramLoad), .ramWord(ramWord),
        .dacSliceSelect(dacSliceSelect), .ramReadSelect(ramReadSelect), .dacRdData(dacRdData),
        .dacRdValid(dacRdValid), .loadData(loadData), .loadValid(loadValid),
        .bootstrapMode(bootstrapMode), .hsThreshold(hsThreshold), .flagBits(flagBits),
        .freewheelAuto(freewheelAuto), .freewheelDriver(freewheelDriver),
        .controlBits(controlBits));
    // Free-running 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samplesChecked++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tallyAndFinish();
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One load or one DAC access, launched just after an edge
    task automatic load(input logic [15:0] d);
        @(posedge ref_clk);
        #1;
        ramLoad = 1'b1;
        ramWord = d;
        @(posedge ref_clk);
        #1;
        ramLoad = 1'b0;
        ramWord = ~d;
    endtask
    task automatic dac(input logic sh, input logic wr, input logic [15:0] d);
        @(posedge ref_clk);
        #1;
        {dacAccess, dacShared, dacWrite, dacWrData} = {1'b1, sh, wr, d};
        @(posedge ref_clk);
        #1;
        dacAccess = 1'b0;
        dacWrData = ~d;
    endtask
    function automatic logic [15:0] ramExp(input int md, input logic [15:0] d);
        case (md)
            0: return d;
            1: return {8'h00, d[7:0]};
            2: return {8'h00, d[15:8]};
            default: return {d[7:0], d[15:8]};
        endcase
    endfunction
    // Slice model: bit 0 of the mode selects value or 4h, bit 1 offset or negative
    function automatic logic [15:0] dacExp(input logic [1:0] md, input logic sh);
        dacExp = 16'h0000;
        if (!sh) begin
            if (md[0]) dacExp[7:0] = mVal;
            if (md[1]) dacExp[13:8] = mOff;
        end else begin
            if (md == 2'h0) dacExp[7:0] = mBst;
            if (md[0]) dacExp[7:0] = mH4;
            if (md[1]) dacExp[11:8] = mNeg;
        end
    endfunction
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        tallyAndFinish();
    end
    // Main sequence
    initial begin
        seed = 31701;
        {miscompares, samplesChecked} = 0;
        {reset_n, dacAccess, dacShared, dacWrite, ramLoad} = 0;
        {dacWrData, ramWord, outputAccess, firstShortcut, hsReg} = 0;
        {mFlags, mCtrl, mVal, mH4, mBst, mOff, mNeg, mMask} = 0;
        mBs = 10'h3ff;
        repeat (16) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        chk("slice", 16'h0001, 16'(dacSliceSelect));
        chk("readmode", 16'h0000, 16'(ramReadSelect));
        chk("bootstrap", 16'(mBs), 16'(bootstrapMode));
        chk("fwauto", 16'h0000, 16'(freewheelAuto));
        chk("flags", 16'h0000, flagBits);
        for (m = 0; m < 4; m++) begin
            seq.issue(16'h3580 | 16'(m));
            chk("readmode", 16'(m), 16'(ramReadSelect));
            repeat (3) begin
                w = 16'($random(seed));
                load(w);
                chk("load", ramExp(m, w), loadData);
                chk("loadvalid", 16'h0001, 16'(loadValid));
            end
        end
        for (m = 0; m < 4; m++) begin
            seq.issue(16'h3584 | 16'(m));
            chk("slice", 16'(m), 16'(dacSliceSelect));
            for (s = 0; s < 2; s++) begin
                w = 16'($random(seed));
                dac(s[0], 1'b1, w);
                if (s == 0 && m[0]) mVal = w[7:0];
                if (s == 0 && m[1]) mOff = w[13:8];
                if (s == 1 && m == 0) mBst = w[7:0];
                if (s == 1 && m[0]) mH4 = w[7:0];
                if (s == 1 && m[1]) mNeg = w[11:8];
            end
            for (s = 0; s < 2; s++) begin
                dac(s[0], 1'b0, 16'h0000);
                chk("dacread", dacExp(m[1:0], s[0]), dacRdData);
                chk("dacvalid", 16'h0001, 16'(dacRdValid));
            end
        end
        seq.issue(16'h3588);
        chk("slice", 16'h0003, 16'(dacSliceSelect));
        for (i = 0; i < 32; i++) begin
            l = 1'($random(seed));
            seq.issue(16'h34e0 | {11'h0, l, 4'(i)});
            mFlags[i%16] = l;
            chk("flags", mFlags, flagBits);
            seq.issue(16'h3740 | {11'h0, l, 1'b0, 3'(i)});
            mCtrl[i%8] = l;
            chk("ctrl", 16'(mCtrl), 16'(controlBits));
        end
        hsReg = 15'($random(seed));
        for (i = 0; i < 8; i++) begin
            c = 3'($random(seed));
            outputAccess = 12'($random(seed));
            seq.issue(16'h3520 | 16'(c));
            for (h = 0; h < 5; h++) begin
                if (outputAccess[h] && c[1:0] != 2'h0) mBs[h*2+:2] = c[1:0];
                if (outputAccess[h]) mMask[h] = c[2];
            end
            @(posedge ref_clk);
            #1;
            chk("bootstrap", 16'(mBs), 16'(bootstrapMode));
            for (h = 0; h < 5; h++) begin
                w = mMask[h] ? 16'h0000 : 16'(hsReg[h*3+:3]);
                chk("threshold", w, 16'(hsThreshold[h*3+:3]));
            end
        end
        for (h = 0; h < 5; h++) begin
            drv = (h == 0) ? 4'h9 : (h == 1) ? 4'ha : (h == 2) ? 4'hb : (h == 3) ? 4'h4 : 4'h8;
            firstShortcut = 4'(h);
            outputAccess = 12'hfff;
            seq.issue(16'h3591);
            chk("fwauto", 16'h0001, 16'(freewheelAuto));
            chk("fwdriver", 16'(drv), 16'(freewheelDriver));
            outputAccess = ~(12'h001 << drv);
            seq.issue(16'h3590);
            chk("fwauto", 16'h0001, 16'(freewheelAuto));
            outputAccess = 12'hfff;
            seq.issue(16'h3590);
            chk("fwdriver", 16'h000c, 16'(freewheelDriver));
            chk("fwauto", 16'h0000, 16'(freewheelAuto));
        end
        tallyAndFinish();
    end
endmodule
bind microcore_mode_set mode_set_props #(.NUM_HS(NUM_HS), .NUM_FLAGS(NUM_FLAGS)) u_props (
    .ref_clk(ref_clk), .reset_n(reset_n), .instrValid(instrValid), .instrWord(instrWord),
    .outputAccess(outputAccess), .dacAccess(dacAccess), .dacWrite(dacWrite),
    .ramLoad(ramLoad), .ramWord(ramWord), .dacSliceSelect(dacSliceSelect),
    .ramReadSelect(ramReadSelect), .dacRdValid(dacRdValid), .loadData(loadData),
    .loadValid(loadValid), .bootstrapMode(bootstrapMode), .flagBits(flagBits),
    .freewheelAuto(freewheelAuto), .freewheelDriver(freewheelDriver),
    .controlBits(controlBits));
